// File: dv/pifs_host.sv
// host controller model: classic wishbone master issuing command traffic.
// assumes a one-clock sequencer slave; the bench timeout ends any hang.
`timescale 1ns/1ps
`default_nettype none

module pifs_host (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output var  logic        cyc_o,
	output var  logic        stb_o,
	output var  logic        we_o,
	output var  logic [3:0]  sel_o,
	output var  logic [7:0]  adr_o,
	output var  logic [31:0] dat_o
);
	initial begin
		{cyc_o, stb_o, we_o} = 3'h0;
		sel_o = 4'h0;
		adr_o = 8'h00;
		dat_o = 32'h00000000;
	end

	// request held until ack is seen at an edge, then released there
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		sel_o <= 4'hf;
		adr_o <= a;
		dat_o <= wd;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		rd = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] unused;
		xfer(1'b1, a, wd, unused);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h00000000, d);
	endtask
endmodule

`default_nettype wire

// File: dv/pifs_seq_props.sv
// port-level checker for the power-up init and input fault sequencer.
// assumes the bench sets INIT_CYCLES to 64 and leaves both fault limits at default.
`timescale 1ns/1ps
`default_nettype none

module pifs_seq_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0]  sel_i,
	input wire logic        we_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        ctrl_pin_i,
	input wire logic [15:0] vin_code_i,
	input wire logic [4:0]  addr_strap_i,
	input wire logic [4:0]  vout_strap_i,
	input wire logic [6:0]  bus_addr_o,
	input wire logic        init_done_o,
	input wire logic        output_enable_o,
	input wire logic        fault_alert_line_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acknowledged next cycle");
	init_time_a: assert property ($fell(rst_i) |-> ##[1:66] init_done_o)
		else $error("init did not finish in time");
	no_out_init_a: assert property (!init_done_o |-> !output_enable_o)
		else $error("output on before init finished");
	addr_fixed_a: assert property (init_done_o |=> $stable(bus_addr_o))
		else $error("bus address moved after init");
	pin_off_a: assert property (!ctrl_pin_i [*4] |-> !output_enable_o)
		else $error("output on with control pin low");
	ov_off_a: assert property ((vin_code_i > 16'h1000) [*3] |-> !output_enable_o)
		else $error("output on during over-voltage");
	uv_off_a: assert property ((vin_code_i < 16'h0500) [*3] |-> !output_enable_o)
		else $error("output on during under-voltage");

	cover property (ack_o && !we_i);
	cover property ($fell(output_enable_o));
	cover property ($fell(fault_alert_line_n_o));
endmodule

bind pifs_seq pifs_seq_props u_props (.*);

`default_nettype wire

// File: dv/test_pifs_seq.sv
// self-checking bench for the power-up init and input fault sequencer.
// assumes shortened init and store counts; thresholds stay at factory values.
`timescale 1ns/1ps
`default_nettype none

module test_pifs_seq;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        pin = 1'b0;
	logic [15:0] vin = 16'h0c00;
	logic [4:0]  astrap = 5'h03;
	logic [31:0] d;
	wire         cyc, stb, we, ack, done, oe, alert_n;
	wire  [3:0]  sel;
	wire  [7:0]  adr;
	wire  [31:0] wdat, rdat;
	wire  [6:0]  baddr;
	int          n_fail = 0;
	int          n_tests = 0;
	int          cyc_cnt = 0;

	always #2.5 clk = ~clk;

	pifs_seq #(.INIT_CYCLES(25'd64), .STORE_CYCLES(25'd32)) DUT (.clk_i(clk), .rst_i(rst),
		.adr_i(adr), .dat_i(wdat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
		.dat_o(rdat), .ack_o(ack), .ctrl_pin_i(pin), .vin_code_i(vin),
		.addr_strap_i(astrap), .vout_strap_i(5'h02), .bus_addr_o(baddr),
		.init_done_o(done), .output_enable_o(oe), .fault_alert_line_n_o(alert_n));
	pifs_host u_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(string n, logic [7:0] a, logic [31:0] e);
		u_host.rd(a, d);
		chk(n, e, d);
	endtask
	task automatic setv(logic [15:0] v);
		vin <= v;
		repeat (8) @(posedge clk);
	endtask
	task automatic clear;
		u_host.wr(8'h20, 32'h5);
		repeat (3) @(posedge clk);
	endtask

	task automatic t_init;
		u_host.wr(8'h00, 32'h0777);
		chk("init_early", 0, done);
		for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge clk);
		chk("init_done", 1, done);
		chk("bus_addr", 32'h5b, baddr);
		rdc("vout_loaded", 8'h00, 32'h0100);
		rdc("status", 8'h24, 32'h0110);
		chk("alert_cml", 0, alert_n);
		clear();
		chk("alert_clr", 1, alert_n);
		$display("t_init finished");
	endtask

	task automatic t_uv;
		pin <= 1'b1;
		setv(16'h0c00);
		chk("oe_on", 1, oe);
		setv(16'h05c0);
		chk("oe_warn", 1, oe);
		rdc("uv_warn", 8'h24, 32'h0502);
		setv(16'h0400);
		chk("oe_uv", 0, oe);
		chk("alert_uv", 0, alert_n);
		setv(16'h0540);
		chk("oe_hyst", 0, oe);
		setv(16'h0c00);
		chk("oe_back", 1, oe);
		chk("alert_hold", 0, alert_n);
		clear();
		chk("alert_off", 1, alert_n);
		$display("t_uv finished");
	endtask

	task automatic t_latch;
		u_host.wr(8'h18, 32'h3);
		setv(16'h1100);
		chk("ov_latch", 0, oe);
		setv(16'h0c00);
		chk("ov_held", 0, oe);
		clear();
		chk("ov_clr", 1, oe);
		setv(16'h0400);
		setv(16'h0c00);
		chk("uv_held", 0, oe);
		pin <= 1'b0;
		repeat (6) @(posedge clk);
		pin <= 1'b1;
		repeat (8) @(posedge clk);
		chk("uv_reen", 1, oe);
		u_host.wr(8'h18, 32'h0);
		setv(16'h1100);
		chk("ov_auto", 0, oe);
		setv(16'h0f80);
		chk("ov_back", 1, oe);
		rdc("ov_stat", 8'h24, 32'h050c);
		setv(16'h0c00);
		clear();
		$display("t_latch finished");
	endtask

	task automatic t_lock;
		u_host.wr(8'h00, 32'h0123);
		rdc("vout_wr", 8'h00, 32'h0123);
		u_host.wr(8'h1c, 32'h1);
		u_host.wr(8'h00, 32'h0456);
		rdc("vout_lock", 8'h00, 32'h0123);
		rdc("cml", 8'h24, 32'h0510);
		rdc("unmapped", 8'h3c, 32'h0);
		u_host.wr(8'h1c, 32'h0);
		u_host.wr(8'h20, 32'h6);
		u_host.rd(8'h24, d);
		chk("busy", 1, d[9]);
		u_host.wr(8'h00, 32'h0999);
		for (int i = 0; i < 60 && d[9] !== 1'b0; i++) u_host.rd(8'h24, d);
		chk("idle", 0, d[9]);
		rdc("vout_busy", 8'h00, 32'h0123);
		$display("t_lock finished");
	endtask

	// mid-run reset with a strap code past the skipped default address
	task automatic t_reset;
		astrap <= 5'h09;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("rst_baddr", 32'h58, baddr);
		chk("rst_oe", 0, oe);
		chk("rst_alert", 1, alert_n);
		rst <= 1'b0;
		for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge clk);
		chk("strap_gap", 32'h62, baddr);
		@(posedge clk);
		chk("oe_after_rst", 1, oe);
		$display("t_reset finished");
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_init();
		t_uv();
		t_latch();
		t_lock();
		t_reset();
		stop_test();
	end
endmodule

`default_nettype wire

// File: hdl/pifs_seq.v
// power-up init and input over/under-voltage supervision with a wishbone
// register slave. assumes strap and vin codes come from converter logic on
// clk_i; the remote-control pin is asynchronous.
//
// Functional notes
// - a lock word marks commands write-protected; writes to them are refused
// - init starts with self test and stored memory check
// - second step measures address strap and fixes bus address
// - third step measures vout strap into operating vout command
// - fourth step copies stored words; strapped vout wins when selected
// - init ends within 20 ms; only then may the pin enable output
// - after init host writes are taken and replace loaded values
// - undervoltage turn-on threshold above turn-off gives hysteresis
// - latched uv mode shuts off until clear or re-enable
// - auto uv mode holds off below turn-off, resumes above turn-on
// - auto uv is default; four commands set thresholds and response
// - input watched continuously for over-voltage
// - latched ov mode shuts off until clear or re-enable
// - auto ov mode holds off and restarts once input falls back
// - auto ov is default; three commands set thresholds and response
// - alert low on unmasked fault or warning until clear or re-enable
// - stored memory written only on store-all; 100 ms busy after
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pifs_regs.vh"

module pifs_seq #(
	parameter [24:0] INIT_CYCLES  = `PIFS_INIT_TIME_MS * 1000 * `PIFS_CLK_MHZ,
	parameter [24:0] STORE_CYCLES = `PIFS_STORE_TIME_MS * 1000 * `PIFS_CLK_MHZ,
	parameter [15:0] VOUT_BASE    = 16'h0099,
	parameter [15:0] VOUT_STEP    = 16'h0010
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [7:0]  adr_i,
	input  wire [31:0] dat_i,
	input  wire [3:0]  sel_i,
	input  wire        we_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire        ctrl_pin_i,
	input  wire [15:0] vin_code_i,
	input  wire [4:0]  addr_strap_i,
	input  wire [4:0]  vout_strap_i,
	output reg  [6:0]  bus_addr_o,
	output reg         init_done_o,
	output reg         output_enable_o,
	output reg         fault_alert_line_n_o
);

	localparam [5:0] ST_TEST = 6'h01;
	localparam [5:0] ST_ADDR = 6'h02;
	localparam [5:0] ST_VOUT = 6'h04;
	localparam [5:0] ST_LOAD = 6'h08;
	localparam [5:0] ST_DONE = 6'h10;
	localparam [5:0] ST_FAIL = 6'h20;

	function [15:0] pifs_default;
		input [2:0] idx;
		begin
			case (idx)
			`PIFS_IDX_VOUT_CMD: pifs_default = `PIFS_DEF_VOUT_CMD;
			`PIFS_IDX_UV_FAULT: pifs_default = `PIFS_DEF_UV_FAULT;
			`PIFS_IDX_VIN_ON:   pifs_default = `PIFS_DEF_VIN_ON;
			`PIFS_IDX_UV_WARN:  pifs_default = `PIFS_DEF_UV_WARN;
			`PIFS_IDX_OV_FAULT: pifs_default = `PIFS_DEF_OV_FAULT;
			`PIFS_IDX_OV_WARN:  pifs_default = `PIFS_DEF_OV_WARN;
			`PIFS_IDX_RESPONSE: pifs_default = `PIFS_DEF_RESPONSE;
			default:            pifs_default = `PIFS_DEF_WR_LOCK;
			endcase
		end
	endfunction

	function [15:0] pifs_default_chk;
		input dummy;
		integer k;
		begin
			pifs_default_chk = 16'h0000;
			for (k = 0; k < `PIFS_NUM_WORDS; k = k + 1) begin
				pifs_default_chk = pifs_default_chk ^ pifs_default(k[2:0]);
			end
		end
	endfunction

	// byte-lane merge of a 16-bit word
	function [15:0] pifs_merge;
		input [15:0] old;
		input [15:0] new_val;
		input [1:0]  sel;
		begin
			pifs_merge = {sel[1] ? new_val[15:8] : old[15:8],
				sel[0] ? new_val[7:0] : old[7:0]};
		end
	endfunction

	reg  [15:0] stored_r [0:`PIFS_NUM_WORDS-1];
	reg  [15:0] oper_r   [0:`PIFS_NUM_WORDS-1];
	reg  [15:0] stored_chk_r;
	reg  [15:0] chk_acc_r;
	reg  [2:0]  idx_r;
	reg  [5:0]  state_r;
	reg  [24:0] init_cnt_r;
	reg  [24:0] store_cnt_r;
	reg  [15:0] strap_vout_r;
	reg         ctrl_s1_r;
	reg         ctrl_s2_r;
	reg         operation_r;
	reg         en_req_d_r;
	reg         uv_low_r;
	reg         uv_latch_r;
	reg         ov_latch_r;
	reg  [5:0]  status_r;
	reg  [5:0]  alert_mask_r;
	integer     i;

	wire        init_done = (state_r == ST_DONE) || (state_r == ST_FAIL);
	wire        bus_req   = cyc_i & stb_i & ~ack_o;
	wire        bus_wr    = bus_req & we_i;
	wire        cmd_hit   = (adr_i[7:5] == 3'h0) && (adr_i[1:0] == 2'h0);
	wire [2:0]  cmd_idx   = adr_i[4:2];
	wire        store_busy = (store_cnt_r != 25'h0000000);
	// lock bit of the lock word itself is ignored so it stays reachable
	wire        locked    = oper_r[`PIFS_IDX_WR_LOCK][cmd_idx] &&
		(cmd_idx != `PIFS_IDX_WR_LOCK);
	wire        cmd_ok    = init_done & ~store_busy & ~locked;
	wire        ctl_wr    = bus_wr & (adr_i == `PIFS_ADR_CONTROL) & sel_i[0];
	wire        clear_req = ctl_wr & dat_i[`PIFS_CTL_CLEAR];
	wire        store_req = ctl_wr & dat_i[`PIFS_CTL_STORE] & init_done & ~store_busy;
	wire        en_req    = ctrl_s2_r & operation_r;
	wire        reenable  = en_req & ~en_req_d_r;
	wire        clear_all = clear_req | reenable;
	wire [15:0] resp      = oper_r[`PIFS_IDX_RESPONSE];
	wire        uv_trip   = vin_code_i < oper_r[`PIFS_IDX_UV_FAULT];
	wire        uv_ok     = vin_code_i > oper_r[`PIFS_IDX_VIN_ON];
	wire        ov_trip   = vin_code_i > oper_r[`PIFS_IDX_OV_FAULT];
	wire        uv_warn   = vin_code_i < oper_r[`PIFS_IDX_UV_WARN];
	wire        ov_warn   = vin_code_i > oper_r[`PIFS_IDX_OV_WARN];
	wire        uv_block  = resp[`PIFS_RESP_UV_LATCH] ? uv_latch_r : uv_low_r;
	wire        ov_block  = resp[`PIFS_RESP_OV_LATCH] ? ov_latch_r : ov_trip;
	wire [5:0]  status_set;

	assign status_set[`PIFS_ST_UV_FAULT] = init_done & uv_trip;
	assign status_set[`PIFS_ST_UV_WARN]  = init_done & uv_warn;
	assign status_set[`PIFS_ST_OV_FAULT] = init_done & ov_trip;
	assign status_set[`PIFS_ST_OV_WARN]  = init_done & ov_warn;
	assign status_set[`PIFS_ST_CML]      = bus_wr & cmd_hit & ~cmd_ok;
	assign status_set[`PIFS_ST_SELFTEST] = (state_r == ST_FAIL);

	// remote-control pin is asynchronous
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_s1_r <= 1'b0;
			ctrl_s2_r <= 1'b0;
		end else begin
			ctrl_s1_r <= ctrl_pin_i;
			ctrl_s2_r <= ctrl_s1_r;
		end
	end

	// init sequencer; walks the stored memory one word per clock
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r      <= ST_TEST;
			idx_r        <= 3'h0;
			chk_acc_r    <= 16'h0000;
			init_cnt_r   <= 25'h0000000;
			bus_addr_o   <= `PIFS_BUS_ADDR_BASE;
			strap_vout_r <= 16'h0000;
		end else begin
			if (!init_done) begin
				init_cnt_r <= init_cnt_r + 25'h0000001;
			end
			case (state_r)
			ST_TEST: begin
				chk_acc_r <= chk_acc_r ^ stored_r[idx_r];
				idx_r     <= idx_r + 3'h1;
				if (idx_r == 3'h7) begin
					state_r <= ((chk_acc_r ^ stored_r[idx_r]) == stored_chk_r) ?
						ST_ADDR : ST_FAIL;
				end
			end
			ST_ADDR: begin
				// the address table skips the device default address
				bus_addr_o <= `PIFS_BUS_ADDR_BASE + {2'b00, addr_strap_i} +
					((addr_strap_i >= `PIFS_BUS_ADDR_GAP) ? 7'h01 : 7'h00);
				state_r    <= ST_VOUT;
			end
			ST_VOUT: begin
				strap_vout_r <= VOUT_BASE + VOUT_STEP * {11'h000, vout_strap_i};
				state_r      <= ST_LOAD;
				idx_r        <= 3'h0;
			end
			ST_LOAD: begin
				idx_r <= idx_r + 3'h1;
				if (idx_r == 3'h7) begin
					state_r <= ST_DONE;
				end
			end
			ST_DONE: state_r <= ST_DONE;
			ST_FAIL: state_r <= ST_FAIL;
			default: state_r <= ST_FAIL;
			endcase
			// a stuck sequence still ends inside the init budget
			if (!init_done && init_cnt_r >= INIT_CYCLES - 25'h0000001) begin
				state_r <= ST_FAIL;
			end
		end
	end

	// operating copy: loaded by init, then overwritten by host writes
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (i = 0; i < `PIFS_NUM_WORDS; i = i + 1) begin
				oper_r[i] <= pifs_default(i[2:0]);
			end
		end else if (state_r == ST_VOUT) begin
			oper_r[`PIFS_IDX_VOUT_CMD] <= VOUT_BASE + VOUT_STEP * {11'h000, vout_strap_i};
		end else if (state_r == ST_LOAD) begin
			if (idx_r == `PIFS_IDX_VOUT_CMD && stored_r[`PIFS_IDX_RESPONSE][`PIFS_RESP_VOUT_PIN]) begin
				oper_r[idx_r] <= strap_vout_r;
			end else begin
				oper_r[idx_r] <= stored_r[idx_r];
			end
		end else if (bus_wr && cmd_hit && cmd_ok) begin
			oper_r[cmd_idx] <= pifs_merge(oper_r[cmd_idx], dat_i[15:0], sel_i[1:0]);
		end
	end

	// stored memory changes only on store-all; then a busy window follows
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (i = 0; i < `PIFS_NUM_WORDS; i = i + 1) begin
				stored_r[i] <= pifs_default(i[2:0]);
			end
			stored_chk_r <= pifs_default_chk(1'b0);
			store_cnt_r  <= 25'h0000000;
		end else if (store_req) begin
			for (i = 0; i < `PIFS_NUM_WORDS; i = i + 1) begin
				stored_r[i] <= oper_r[i];
			end
			stored_chk_r <= oper_r[0] ^ oper_r[1] ^ oper_r[2] ^ oper_r[3] ^
				oper_r[4] ^ oper_r[5] ^ oper_r[6] ^ oper_r[7];
			store_cnt_r  <= STORE_CYCLES;
		end else if (store_busy) begin
			store_cnt_r <= store_cnt_r - 25'h0000001;
		end
	end

	// input supervision and output gating
	always @(posedge clk_i) begin
		if (rst_i) begin
			operation_r          <= 1'b1;
			en_req_d_r           <= 1'b0;
			uv_low_r             <= 1'b1;
			uv_latch_r           <= 1'b0;
			ov_latch_r           <= 1'b0;
			status_r             <= 6'h00;
			alert_mask_r         <= `PIFS_DEF_ALERT_MASK;
			output_enable_o      <= 1'b0;
			fault_alert_line_n_o <= 1'b1;
			init_done_o          <= 1'b0;
		end else begin
			init_done_o <= init_done;
			en_req_d_r  <= en_req;
			if (ctl_wr && init_done) begin
				operation_r <= dat_i[`PIFS_CTL_OPERATION];
			end
			if (bus_wr && adr_i == `PIFS_ADR_ALERT_MASK && sel_i[0]) begin
				alert_mask_r <= dat_i[5:0];
			end
			// turn-off below uv fault, turn-on only above vin_on
			if (uv_trip) begin
				uv_low_r <= 1'b1;
			end else if (uv_ok) begin
				uv_low_r <= 1'b0;
			end
			// a trip in the clearing cycle wins over the clear
			if (init_done && uv_trip) begin
				uv_latch_r <= 1'b1;
			end else if (clear_all) begin
				uv_latch_r <= 1'b0;
			end
			if (init_done && ov_trip) begin
				ov_latch_r <= 1'b1;
			end else if (clear_all) begin
				ov_latch_r <= 1'b0;
			end
			status_r <= status_set | (clear_all ? 6'h00 : status_r);
			fault_alert_line_n_o <= ~|(status_r & ~alert_mask_r);
			output_enable_o <= init_done & en_req & ~uv_block & ~ov_block;
		end
	end

	// wishbone slave: one wait state, ack for one cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= bus_req;
			dat_o <= 32'h00000000;
			if (bus_req && !we_i) begin
				if (cmd_hit) begin
					dat_o <= {16'h0000, oper_r[cmd_idx]};
				end else begin
					case (adr_i)
					`PIFS_ADR_CONTROL:    dat_o <= {29'h0, operation_r, 2'b00};
					`PIFS_ADR_STATUS:     dat_o <= {21'h0, output_enable_o, store_busy,
						init_done, 2'b00, status_r};
					`PIFS_ADR_ALERT_MASK: dat_o <= {26'h0, alert_mask_r};
					`PIFS_ADR_VIN:        dat_o <= {16'h0000, vin_code_i};
					`PIFS_ADR_BUS_ADDR:   dat_o <= {25'h0, bus_addr_o};
					default:              dat_o <= 32'h00000000;
					endcase
				end
			end
		end
	end

endmodule
`default_nettype wire

// File: include/pifs_regs.vh
// register map, field positions, reset values and timing counts of the
// power-up init and input fault sequencer; included by the design file.
`ifndef PIFS_REGS_VH
`define PIFS_REGS_VH

// operating command words, word index = byte offset / 4
`define PIFS_IDX_VOUT_CMD   3'h0
`define PIFS_IDX_UV_FAULT   3'h1
`define PIFS_IDX_VIN_ON     3'h2
`define PIFS_IDX_UV_WARN    3'h3
`define PIFS_IDX_OV_FAULT   3'h4
`define PIFS_IDX_OV_WARN    3'h5
`define PIFS_IDX_RESPONSE   3'h6
`define PIFS_IDX_WR_LOCK    3'h7
`define PIFS_NUM_WORDS      8

// byte addresses of the remaining registers
`define PIFS_ADR_CONTROL    8'h20
`define PIFS_ADR_STATUS     8'h24
`define PIFS_ADR_ALERT_MASK 8'h28
`define PIFS_ADR_VIN        8'h2c
`define PIFS_ADR_BUS_ADDR   8'h30

// response word fields
`define PIFS_RESP_UV_LATCH  0
`define PIFS_RESP_OV_LATCH  1
`define PIFS_RESP_VOUT_PIN  2

// control word fields (clear and store are write-only strobes)
`define PIFS_CTL_CLEAR      0
`define PIFS_CTL_STORE      1
`define PIFS_CTL_OPERATION  2

// status word fields: 0..5 sticky, 8..10 live
`define PIFS_ST_UV_FAULT    0
`define PIFS_ST_UV_WARN     1
`define PIFS_ST_OV_FAULT    2
`define PIFS_ST_OV_WARN     3
`define PIFS_ST_CML         4
`define PIFS_ST_SELFTEST    5
`define PIFS_ST_INIT_DONE   8
`define PIFS_ST_STORE_BUSY  9
`define PIFS_ST_OUTPUT_ON   10

// factory contents of the stored configuration memory, and the alert mask reset value
`define PIFS_DEF_VOUT_CMD   16'h0100
`define PIFS_DEF_UV_FAULT   16'h0500
`define PIFS_DEF_VIN_ON     16'h0580
`define PIFS_DEF_UV_WARN    16'h0600
`define PIFS_DEF_OV_FAULT   16'h1000
`define PIFS_DEF_OV_WARN    16'h0f00
`define PIFS_DEF_RESPONSE   16'h0000
`define PIFS_DEF_WR_LOCK    16'h0000
`define PIFS_DEF_ALERT_MASK 6'h00

// timing and bus address table
`define PIFS_CLK_MHZ        200
`define PIFS_INIT_TIME_MS   20
`define PIFS_STORE_TIME_MS  100
`define PIFS_BUS_ADDR_BASE  7'h58
`define PIFS_BUS_ADDR_GAP   5'h09

`endif
